// ==== hdl/epr_pin_gate.sv ====
/*
 * per-regulator gating of the external enable pins by the selection bits.
 * assumes: pins are synchronous to aclk; selection vectors come from flops.
 */
`timescale 1ns/1ps
`default_nettype none

module epr_pin_gate (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic                  enable_pin_two,
    input  wire logic                  enable_pin_three,
    input  wire logic                  enable_pin_four,
    input  wire epr_pkg::epr_reg_vec_t sel_two,
    input  wire epr_pkg::epr_reg_vec_t sel_three,
    input  wire epr_pkg::epr_reg_vec_t sel_four,
    output var  epr_pkg::epr_reg_vec_t pin_enable_request,
    output var  epr_pkg::epr_reg_vec_t pin_governed
);
    import epr_pkg::*;

    // ------------------------------------------------------------------
    // per regulator gating
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `EPR_NUM_REGULATORS; g = g + 1) begin : g_reg
            wire logic next_req;
            wire logic next_gov;
            // a pin whose bit is clear contributes nothing at all
            assign next_req = (enable_pin_two   & sel_two[g])   |
                              (enable_pin_three & sel_three[g]) |
                              (enable_pin_four  & sel_four[g]);  // [RULE6]
            assign next_gov = sel_two[g] | sel_three[g] | sel_four[g];

            // registered so the outputs come straight from flops
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    pin_enable_request[g] <= 1'b0;
                    pin_governed[g]       <= 1'b0;
                end else begin
                    pin_enable_request[g] <= next_req;
                    pin_governed[g]       <= next_gov;
                end
            end
        end
    endgenerate
endmodule

`default_nettype wire

// ==== hdl/epr_top.sv ====
/*
 * enable pin routing register bank: five selection registers behind an
 * axi4-lite slave, steering three enable pins onto fourteen regulators.
 * assumes: aresetn doubles as the power-on reset; factory values arrive
 * on the otp_* ports and are stable while aresetn is low.
 */
// Summary of operation
// [RULE1] register 0x33 bits 7..0 hand linear regulators 8..1 to pin three.
// [RULE2] register 0x34 bits 5..0 hand bucks 4..1 and linear 10,9 to pin three.
// [RULE3] register 0x35 bits 7..0 hand linear regulators 8..1 to pin four.
// [RULE4] register 0x36 bits 5..0 hand bucks 4..1 and linear 10,9 to pin four.
// [RULE5] pin two buck register bits 3..0 hand bucks 2,1 and linear 10,9 to pin two.
// [RULE6] a clear selection bit means that pin has no say over that regulator.
// [RULE7] bits 7 and 6 of each buck register ignore writes and read zero.
// [RULE8] power-on reset loads factory values and every selection bit is read/write.
// [RULE9] a written bit steers the gating from the next cycle and reads return it.
`timescale 1ns/1ps
`default_nettype none

`include "epr_regs.svh"

module epr_top (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // axi4-lite write address
    input  wire epr_pkg::epr_addr_t s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output var  logic              s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output var  logic              s_axi_wready,
    // axi4-lite write response
    output var  logic [1:0]        s_axi_bresp,
    output var  logic              s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // axi4-lite read address
    input  wire epr_pkg::epr_addr_t s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output var  logic              s_axi_arready,
    // axi4-lite read data
    output var  logic [31:0]       s_axi_rdata,
    output var  logic [1:0]        s_axi_rresp,
    output var  logic              s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // factory programmed reset values
    input  wire epr_pkg::epr_byte_t otp_pin2_buck_select,
    input  wire epr_pkg::epr_byte_t otp_pin3_linear_select,
    input  wire epr_pkg::epr_byte_t otp_pin3_buck_select,
    input  wire epr_pkg::epr_byte_t otp_pin4_linear_select,
    input  wire epr_pkg::epr_byte_t otp_pin4_buck_select,
    // external enable pins
    input  wire logic              enable_pin_two,
    input  wire logic              enable_pin_three,
    input  wire logic              enable_pin_four,
    // towards the regulator enable logic
    output var  epr_pkg::epr_reg_vec_t pin_enable_request,
    output var  epr_pkg::epr_reg_vec_t pin_governed
);
    import epr_pkg::*;

    // ------------------------------------------------------------------
    // register table
    // ------------------------------------------------------------------
    // slot order: pin2 buck, pin3 linear, pin3 buck, pin4 linear, pin4 buck
    localparam epr_byte_t IDX [`EPR_NUM_REGS] = '{
        `EPR_IDX_PIN2_BUCK, `EPR_IDX_PIN3_LINEAR, `EPR_IDX_PIN3_BUCK,
        `EPR_IDX_PIN4_LINEAR, `EPR_IDX_PIN4_BUCK};
    localparam epr_byte_t MASK [`EPR_NUM_REGS] = '{
        `EPR_MASK_PIN2_LOW, `EPR_MASK_LINEAR, `EPR_MASK_BUCK,
        `EPR_MASK_LINEAR, `EPR_MASK_BUCK};

    epr_byte_t sel [`EPR_NUM_REGS];
    epr_byte_t otp [`EPR_NUM_REGS];

    assign otp[0] = otp_pin2_buck_select;
    assign otp[1] = otp_pin3_linear_select;
    assign otp[2] = otp_pin3_buck_select;
    assign otp[3] = otp_pin4_linear_select;
    assign otp[4] = otp_pin4_buck_select;

    // ------------------------------------------------------------------
    // write channel state
    // ------------------------------------------------------------------
    logic       aw_have;
    logic       w_have;
    epr_addr_t  aw_addr;
    logic [7:0] w_byte;
    logic       w_lane0;

    wire logic aw_take;
    wire logic w_take;
    wire logic do_write;
    wire logic next_aw_have;
    wire logic next_w_have;
    wire logic next_bvalid;

    // address and data are taken independently, in either order
    assign aw_take      = s_axi_awvalid & s_axi_awready;
    assign w_take       = s_axi_wvalid & s_axi_wready;
    // the write happens once both halves are held, one cycle after the later one is taken
    assign do_write     = aw_have & w_have & ~s_axi_bvalid;
    assign next_aw_have = (aw_have | aw_take) & ~do_write;
    assign next_w_have  = (w_have | w_take) & ~do_write;
    assign next_bvalid  = (s_axi_bvalid & ~s_axi_bready) | do_write;

    // ------------------------------------------------------------------
    // write address decode
    // ------------------------------------------------------------------
    wire logic [`EPR_NUM_REGS-1:0] wr_hit;
    wire logic                     wr_mapped;
    wire logic                     wr_aligned;

    assign wr_aligned = (aw_addr[1:0] == 2'h0);

    // ------------------------------------------------------------------
    // read address decode
    // ------------------------------------------------------------------
    wire logic [`EPR_NUM_REGS-1:0] rd_hit;
    wire logic                     rd_mapped;
    wire logic                     rd_aligned;
    wire logic                     ar_take;
    wire logic                     next_rvalid;
    epr_byte_t                     rd_byte;

    assign rd_aligned  = (s_axi_araddr[1:0] == 2'h0);
    assign ar_take     = s_axi_arvalid & s_axi_arready;
    assign next_rvalid = (s_axi_rvalid & ~s_axi_rready) | ar_take;

    // ------------------------------------------------------------------
    // selection registers, one slot per generate pass
    // ------------------------------------------------------------------
    genvar r;
    generate
        for (r = 0; r < `EPR_NUM_REGS; r = r + 1) begin : g_sel
            // the printed index sits in the upper six address bits
            assign wr_hit[r] = wr_aligned & (aw_addr[7:2] == IDX[r][5:0]);
            assign rd_hit[r] = rd_aligned &
                               (s_axi_araddr[7:2] == IDX[r][5:0]);

            // reset takes the factory value, not a constant
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    sel[r] <= otp[r] & MASK[r];                  // [RULE8]
                end else if (do_write & wr_hit[r] & w_lane0) begin
                    // bits outside the mask never store a write
                    sel[r] <= w_byte & MASK[r];                  // [RULE7]
                end
            end
        end
    endgenerate

    assign wr_mapped = |wr_hit;
    assign rd_mapped = |rd_hit;

    // read mux; reserved bits are already zero in storage
    always_comb begin
        rd_byte = 8'h00;
        for (int i = 0; i < `EPR_NUM_REGS; i++) begin
            if (rd_hit[i]) begin
                rd_byte = sel[i];                                // [RULE9]
            end
        end
    end

    // ------------------------------------------------------------------
    // write channel flops
    // ------------------------------------------------------------------
    // ready drops while a half is held so the master keeps the other one
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have       <= 1'b0;
            w_have        <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
        end else begin
            aw_have       <= next_aw_have;
            w_have        <= next_w_have;
            s_axi_awready <= ~next_aw_have & ~next_bvalid;
            s_axi_wready  <= ~next_w_have & ~next_bvalid;
            s_axi_bvalid  <= next_bvalid;
        end
    end

    // captured payloads; only byte lane 0 carries register data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr <= 8'h00;
            w_byte  <= 8'h00;
            w_lane0 <= 1'b0;
        end else begin
            if (aw_take) begin
                aw_addr <= s_axi_awaddr;
            end
            if (w_take) begin
                w_byte  <= s_axi_wdata[7:0];
                w_lane0 <= s_axi_wstrb[0];
            end
        end
    end

    // response code; an unmapped or misaligned address is refused
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bresp <= `EPR_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bresp <= wr_mapped ? `EPR_RESP_OKAY : `EPR_RESP_SLVERR;
        end
    end

    // ------------------------------------------------------------------
    // read channel flops
    // ------------------------------------------------------------------
    // data sampled at the address edge, so a read shows the stored value
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `EPR_RESP_OKAY;
        end else begin
            s_axi_arready <= ~next_rvalid;
            s_axi_rvalid  <= next_rvalid;
            if (ar_take) begin
                s_axi_rdata <= {24'h00_0000, rd_byte};           // [RULE9]
                s_axi_rresp <= rd_mapped ? `EPR_RESP_OKAY
                                         : `EPR_RESP_SLVERR;
            end
        end
    end

    // ------------------------------------------------------------------
    // routing of register fields onto the regulator vectors
    // ------------------------------------------------------------------
    // vector layout: bits 0..9 linear 1..10, bits 10..13 buck 1..4
    epr_reg_vec_t vec_two;
    epr_reg_vec_t vec_three;
    epr_reg_vec_t vec_four;

    // pin two: only bucks 1,2 and linear 9,10 live in this bank
    assign vec_two   = {2'b00, sel[0][3:2], sel[0][1:0],
                        8'h00};                                  // [RULE5]
    // pin three: linear 8..1 below, then linear 10,9 and bucks 4..1
    assign vec_three = {sel[2][`EPR_BUCK_BUCK_MSB:`EPR_BUCK_BUCK_LSB],
                        sel[2][`EPR_BUCK_LIN_MSB:`EPR_BUCK_LIN_LSB], // [RULE2]
                        sel[1]};                                 // [RULE1]
    // pin four uses the same layout for its two registers
    assign vec_four  = {sel[4][`EPR_BUCK_BUCK_MSB:`EPR_BUCK_BUCK_LSB],
                        sel[4][`EPR_BUCK_LIN_MSB:`EPR_BUCK_LIN_LSB], // [RULE4]
                        sel[3]};                                 // [RULE3]

    // ------------------------------------------------------------------
    // pin gating
    // ------------------------------------------------------------------
    // gating sees the register outputs directly, so a write takes hold at
    // the edge after it lands; the extra output flop is the price of
    // registered outputs
    epr_pin_gate i_epr_pin_gate (
        .aclk               (aclk),
        .aresetn            (aresetn),
        .enable_pin_two     (enable_pin_two),
        .enable_pin_three   (enable_pin_three),
        .enable_pin_four    (enable_pin_four),
        .sel_two            (vec_two),
        .sel_three          (vec_three),
        .sel_four           (vec_four),
        .pin_enable_request (pin_enable_request),
        .pin_governed       (pin_governed)
    );                                                           // [RULE6]
endmodule

`default_nettype wire

// ==== shared/epr_pkg.sv ====
/*
 * types shared by the enable pin routing design files.
 * assumes: epr_regs.svh is on the include path.
 */
`default_nettype none

`include "epr_regs.svh"

package epr_pkg;
    // one selection register value
    typedef logic [7:0] epr_byte_t;
    // one bit per regulator: linear 1..10 in bits 0..9, buck 1..4 above
    typedef logic [`EPR_NUM_REGULATORS-1:0] epr_reg_vec_t;
    // byte address on the register bus
    typedef logic [7:0] epr_addr_t;
endpackage

`default_nettype wire

// ==== shared/epr_regs.svh ====
/*
 * register offsets, field layouts, reset masks and bus codes for the
 * enable pin routing register bank.
 * assumes: included by bare name from the package and the design files.
 */
`ifndef EPR_REGS_SVH
`define EPR_REGS_SVH

// ----------------------------------------------------------------------
// register indices; the byte address on the bus is four times the index
// ----------------------------------------------------------------------
`define EPR_IDX_PIN2_BUCK    8'h32
`define EPR_IDX_PIN3_LINEAR  8'h33
`define EPR_IDX_PIN3_BUCK    8'h34
`define EPR_IDX_PIN4_LINEAR  8'h35
`define EPR_IDX_PIN4_BUCK    8'h36

// ----------------------------------------------------------------------
// writable bit masks; bits outside a mask read as zero
// ----------------------------------------------------------------------
`define EPR_MASK_LINEAR      8'hff
`define EPR_MASK_BUCK        8'h3f
`define EPR_MASK_PIN2_LOW    8'h0f

// ----------------------------------------------------------------------
// field positions of the buck and linear bits inside the pin three and pin four buck selection registers
// ----------------------------------------------------------------------
`define EPR_BUCK_BUCK_MSB    5
`define EPR_BUCK_BUCK_LSB    2
`define EPR_BUCK_LIN_MSB     1
`define EPR_BUCK_LIN_LSB     0

// ----------------------------------------------------------------------
// regulator vector layout and bus answers
// ----------------------------------------------------------------------
`define EPR_NUM_REGS         5
`define EPR_NUM_REGULATORS   14
`define EPR_RESP_OKAY        2'b00
`define EPR_RESP_SLVERR      2'b10

`endif

// ==== tb/epr_monitor.sv ====
/*
 * checker for the enable pin routing bank, bound to epr_top.
 * assumes: sees epr_top ports only; one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

`include "epr_regs.svh"

module epr_monitor (
    input wire logic                  aclk,
    input wire logic                  aresetn,
    input wire logic                  s_axi_awvalid,
    input wire logic                  s_axi_awready,
    input wire logic                  s_axi_wvalid,
    input wire logic                  s_axi_wready,
    input wire logic                  s_axi_bvalid,
    input wire logic                  s_axi_arvalid,
    input wire logic                  s_axi_arready,
    input wire logic [31:0]           s_axi_rdata,
    input wire logic [1:0]            s_axi_rresp,
    input wire logic                  s_axi_rvalid,
    input wire logic                  enable_pin_two,
    input wire logic                  enable_pin_three,
    input wire logic                  enable_pin_four,
    input wire epr_pkg::epr_reg_vec_t pin_enable_request,
    input wire epr_pkg::epr_reg_vec_t pin_governed
);
    import epr_pkg::*;
    // ------------------------------------------------------------------
    // handshake steps and pin relations
    // ------------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_write_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_read_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_write_answer: assert property (
        s_write_taken |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    a_read_answer: assert property (
        s_read_taken |=> s_axi_rvalid)
        else $error("read answer late");
    a_write_blocks: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while answering");
    a_read_blocks: assert property (
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while answering");
    a_upper_zero: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_error_data: assert property (
        s_axi_rvalid && s_axi_rresp != `EPR_RESP_OKAY |-> s_axi_rdata == 32'h0)
        else $error("error read carries data");
    a_ungoverned_off: assert property (
        (pin_enable_request & ~pin_governed) == '0)
        else $error("request on ungoverned regulator");
    a_pins_quiet: assert property (
        !(enable_pin_two || enable_pin_three || enable_pin_four)
        |=> pin_enable_request == '0)
        else $error("request without any pin");
    a_all_pins_full: assert property (
        enable_pin_two && enable_pin_three && enable_pin_four
        |=> pin_enable_request == pin_governed)
        else $error("request differs from routing");
endmodule

bind epr_top epr_monitor i_epr_monitor (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .enable_pin_two, .enable_pin_three, .enable_pin_four,
    .pin_enable_request, .pin_governed);

`default_nettype wire

// ==== tb/epr_pin_host.sv ====
/*
 * model of the host that drives the three enable pins.
 * assumes: pins are sampled by the bank on aclk, so they change after edges.
 */
`timescale 1ns/1ps
`default_nettype none

module epr_pin_host (
    input  wire logic       aclk,
    input  wire logic [2:0] want,
    output var  logic       enable_pin_two,
    output var  logic       enable_pin_three,
    output var  logic       enable_pin_four
);
    // pins follow the wanted pattern one edge later, as a host gpio would
    always_ff @(posedge aclk) begin
        enable_pin_two   <= want[0];
        enable_pin_three <= want[1];
        enable_pin_four  <= want[2];
    end
endmodule

`default_nettype wire

// ==== tb/epr_top_bench.sv ====
/*
 * self-checking bench for the enable pin routing bank.
 * assumes: epr_top, epr_pin_host and the shared package are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

`include "epr_regs.svh"

module epr_top_bench;
    import epr_pkg::*;
    logic         aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
    logic         bready, arvalid, arready, rvalid, rready, p2, p3, p4;
    epr_addr_t    awaddr, araddr;
    logic [31:0]  wdata, rdata, seed, d;
    logic [3:0]   wstrb;
    logic [1:0]   bresp, rresp, r;
    logic [2:0]   want;
    epr_byte_t    otp [5];
    epr_byte_t    sh [5];
    epr_reg_vec_t req, gov;
    int           n_mismatch, total_checks, cycles, i;

    epr_top i_epr_top (.aclk, .aresetn, .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .otp_pin2_buck_select(otp[0]), .otp_pin3_linear_select(otp[1]),
        .otp_pin3_buck_select(otp[2]), .otp_pin4_linear_select(otp[3]),
        .otp_pin4_buck_select(otp[4]), .enable_pin_two(p2),
        .enable_pin_three(p3), .enable_pin_four(p4),
        .pin_enable_request(req), .pin_governed(gov));
    epr_pin_host i_epr_pin_host (.aclk, .want, .enable_pin_two(p2),
        .enable_pin_three(p3), .enable_pin_four(p4));

    // ------------------------------------------------------------------
    // helpers: random source, expectations, bus cycles
    // ------------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic epr_addr_t addr_of(int k);
        return epr_addr_t'((`EPR_IDX_PIN2_BUCK + k) * 4);
    endfunction
    function automatic epr_byte_t mask_of(int k);
        return k == 0 ? `EPR_MASK_PIN2_LOW : (k % 2 ? `EPR_MASK_LINEAR : `EPR_MASK_BUCK);
    endfunction
    // pin two has no linear 1..8 half here, so its low byte stays clear
    function automatic epr_reg_vec_t sel_of(int p);
        if (p == 2) return {2'b00, sh[0][3:0], 8'h00};
        if (p == 3) return {sh[2][5:0], sh[1]};
        return {sh[4][5:0], sh[3]};
    endfunction
    task automatic results();
        if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // valid and payload held until each own ready edge
    task automatic axi_write(input epr_addr_t a, input epr_byte_t v,
                             input logic [3:0] s);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, v};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask
    task automatic axi_read(input epr_addr_t a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask
    // expected outputs from the shadow copy and the wanted pin pattern
    function automatic epr_reg_vec_t gov_of();
        return sel_of(2) | sel_of(3) | sel_of(4);
    endfunction
    function automatic epr_reg_vec_t req_of();
        return (want[0] ? sel_of(2) : '0) | (want[1] ? sel_of(3) : '0) |
               (want[2] ? sel_of(4) : '0);
    endfunction
    task automatic verify_all();
        for (int k = 0; k < 5; k++) begin
            axi_read(addr_of(k));
            check("read resp", r, `EPR_RESP_OKAY);
            check("read data", d, sh[k]);
        end
        check("governed", gov, gov_of());
        check("request", req, req_of());
    endtask
    task automatic do_reset();
        @(posedge aclk);
        aresetn <= 1'b0;
        for (int k = 0; k < 5; k++) otp[k] <= epr_byte_t'(rnd());
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        for (int k = 0; k < 5; k++) sh[k] = otp[k] & mask_of(k);
        verify_all();
    endtask

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    // hang guard: the whole run needs about a thousand cycles
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            results();
        end
    end

    initial begin
        seed = 32'd29413;
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb, want, n_mismatch, total_checks} = '0;
        cycles = 0;
        foreach (otp[k]) otp[k] = 8'h00;
        do_reset();
        for (int v = 0; v < 2; v++) begin
            for (int k = 0; k < 5; k++) begin
                axi_write(addr_of(k), v ? 8'h00 : 8'hff, 4'h1);
                sh[k] = (v ? 8'h00 : 8'hff) & mask_of(k);
            end
            want <= 3'b111;
            verify_all();
        end
        repeat (40) begin
            i = rnd() % 5;
            d = rnd();
            axi_write(addr_of(i), d[7:0], 4'h1);
            check("write resp", r, `EPR_RESP_OKAY);
            sh[i] = d[7:0] & mask_of(i);
            @(posedge aclk);
            check("governed next", gov, gov_of());
            want <= 3'(rnd());
            verify_all();
        end
        // unmapped, beyond the bank, misaligned; then a write with lane 0 off
        foreach (otp[k]) begin
            if (k > 2) break;
            axi_write(k == 0 ? 8'hc4 : (k == 1 ? 8'hdc : 8'hcd), 8'hff, 4'h1);
            check("bad write resp", r, `EPR_RESP_SLVERR);
            axi_read(k == 0 ? 8'hc4 : (k == 1 ? 8'hdc : 8'hcd));
            check("bad read resp", r, `EPR_RESP_SLVERR);
            check("bad read data", d, 32'h0);
        end
        axi_write(addr_of(1), ~sh[1], 4'he);
        check("no lane resp", r, `EPR_RESP_OKAY);
        verify_all();
        do_reset();
        results();
    end
endmodule

`default_nettype wire
